// *** rtl/urp_pkg.sv ***
package urp_pkg;
    // Register word offsets (byte addresses)
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_CSA = 8'h04;
    localparam logic [7:0] OFF_CSB = 8'h08;
    localparam logic [7:0] OFF_PORT = 8'h0c;
    // serial_ctrl_status_a fields
    localparam int CSA_RXC = 7;
    localparam int CSA_FE = 4;
    localparam int CSA_OR = 3;
    // serial_ctrl_status_b fields
    localparam int CSB_RECEIVER_ENABLE = 4;
    localparam int CSB_CHR9 = 2;
    localparam int CSB_RXB8 = 1;
    localparam int CSB_TXB8 = 0;
    // Port control register fields
    localparam int PRT_DIR = 0;
    localparam int PRT_OUT = 1;
    localparam logic [7:0] CSB_RESET = 8'h00;
    // Sampling
    localparam logic [3:0] SMP_FIRST = 4'h7;
    localparam logic [3:0] SMP_MID = 4'h8;
    localparam logic [3:0] SMP_LAST = 4'h9;
    localparam logic [3:0] SMP_END = 4'hf;
    localparam logic [3:0] BITS8 = 4'h8;
    localparam logic [3:0] BITS9 = 4'h9;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b10,
        ST_STOP = 2'b11
    } urp_state_t;
endpackage

// *** rtl/urp_rx_engine.sv ***
`timescale 1ns/1ns
module urp_rx_engine (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Control
    input wire logic rx_enable,
    input wire logic nine_bit,
    input wire logic sample_tick,
    input wire logic rx_line,
    // Character out
    output logic char_done,
    output logic [8:0] char_data,
    output logic char_stop_ok
);
    urp_pkg::urp_state_t state_q, state_d;
    logic [3:0] tick_q;
    logic [3:0] bit_q;
    logic [2:0] vote_q;
    logic [8:0] shift_q;
    logic line_q;
    wire [3:0] nbits = nine_bit ? urp_pkg::BITS9 : urp_pkg::BITS8;
    wire in_win = tick_q >= urp_pkg::SMP_FIRST && tick_q <= urp_pkg::SMP_LAST;
    wire bit_end = sample_tick && tick_q == urp_pkg::SMP_END;
    wire decide = sample_tick && tick_q == urp_pkg::SMP_LAST;
    wire [2:0] vote_next = {vote_q[1:0], line_q};
    wire maj3 = (vote_next[0] & vote_next[1]) | (vote_next[0] & vote_next[2])
        | (vote_next[1] & vote_next[2]);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            urp_pkg::ST_IDLE:
                if (!line_q)
                    state_d = urp_pkg::ST_START;
            urp_pkg::ST_START:
                if (decide && maj3)
                    state_d = urp_pkg::ST_IDLE;
                else if (bit_end)
                    state_d = urp_pkg::ST_DATA;
            urp_pkg::ST_DATA:
                if (bit_end && bit_q == nbits - 4'h1)
                    state_d = urp_pkg::ST_STOP;
            urp_pkg::ST_STOP:
                if (decide)
                    state_d = urp_pkg::ST_IDLE;
        endcase
        if (!rx_enable)
            state_d = urp_pkg::ST_IDLE;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= urp_pkg::ST_IDLE;
            tick_q <= 4'h0;
            bit_q <= 4'h0;
            vote_q <= 3'h7;
            shift_q <= 9'h000;
            line_q <= 1'b1;
            char_done <= 1'b0;
            char_data <= 9'h000;
            char_stop_ok <= 1'b0;
        end
        else if (clk_en)
        begin
            line_q <= rx_line;
            state_q <= state_d;
            char_done <= 1'b0;
            if (state_q == urp_pkg::ST_IDLE)
            begin
                tick_q <= 4'h0;
                bit_q <= 4'h0;
            end
            else if (sample_tick)
            begin
                tick_q <= tick_q + 4'h1;
                if (in_win)
                    vote_q <= vote_next;
                if (bit_end && state_q == urp_pkg::ST_DATA)
                    bit_q <= bit_q + 4'h1;
                if (decide && state_q == urp_pkg::ST_DATA)
                begin
                    // LSB first; a 9-bit char fills all bits, 8-bit leaves bit 8 zero
                    if (nine_bit)
                        shift_q <= {maj3, shift_q[8:1]};
                    else
                        shift_q <= {1'b0, maj3, shift_q[7:1]};
                end
                if (decide && state_q == urp_pkg::ST_STOP)
                begin
                    char_done <= 1'b1;
                    char_data <= shift_q;
                    char_stop_ok <= maj3;
                end
            end
        end
    end

    a_stop_vote: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && sample_tick && state_q == urp_pkg::ST_STOP && tick_q == urp_pkg::SMP_LAST
        |=> char_done && char_stop_ok == $past(maj3))
        else $error("stop vote not reported");
    a_vote_window: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && sample_tick && state_q != urp_pkg::ST_IDLE && !in_win
        |=> vote_q == $past(vote_q))
        else $error("sample taken outside window");
    a_start_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && rx_enable && state_q == urp_pkg::ST_START && decide && maj3
        |=> state_q == urp_pkg::ST_IDLE)
        else $error("noise start not rejected");
    a_shift_in: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && state_q == urp_pkg::ST_DATA && decide && nine_bit
        |=> shift_q[8] == $past(maj3))
        else $error("bit not shifted in");
endmodule

// *** rtl/urp_uart_rx.sv ***
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
module urp_uart_rx (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Baud sample tick (16 per bit)
    input wire logic sample_tick,
    // Receive pin
    input wire logic rx_pin_in,
    output logic rx_pin_out,
    output logic rx_pin_oe,
    output logic rx_pin_pullup,
    // Transmit side
    output logic [7:0] tx_data,
    output logic tx_ninth,
    output logic tx_load
);
    logic [7:0] csb_q;
    logic [1:0] port_q;
    logic [8:0] rdr_q;
    logic rxc_q;
    logic fe_q;
    logic or_q;
    logic or_pend_q;
    logic char_done;
    logic char_stop_ok;
    logic [8:0] char_data;

    wire access = psel && penable && clk_en;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire hit_data = paddr == urp_pkg::OFF_DATA;
    wire hit_csa = paddr == urp_pkg::OFF_CSA;
    wire hit_csb = paddr == urp_pkg::OFF_CSB;
    wire hit_port = paddr == urp_pkg::OFF_PORT;
    wire mapped = hit_data || hit_csa || hit_csb || hit_port;
    wire data_read = rd && hit_data;
    wire rx_en = csb_q[urp_pkg::CSB_RECEIVER_ENABLE];
    wire nine = csb_q[urp_pkg::CSB_CHR9];
    // Receiver owns pin while enabled; otherwise the port drives it when PRT_DIR is set
    wire line_in = rx_en ? rx_pin_in : 1'b1;
    wire overrun = char_done && rxc_q && !data_read;

    wire [7:0] csa_val = {rxc_q, 2'b00, fe_q, or_q, 3'b000};
    wire [7:0] csb_val = {csb_q[7:2], rdr_q[8], csb_q[0]};
    wire [31:0] rd_mux = hit_data ? {24'h000000, rdr_q[7:0]} :
        hit_csa ? {24'h000000, csa_val} :
        hit_csb ? {24'h000000, csb_val} :
        hit_port ? {30'h0, port_q} : 32'h0;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign rx_pin_oe = !rx_en && port_q[urp_pkg::PRT_DIR];
    assign rx_pin_out = port_q[urp_pkg::PRT_OUT];
    assign rx_pin_pullup = rx_pin_oe ? 1'b0 : port_q[urp_pkg::PRT_OUT];

    urp_rx_engine u_engine (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .rx_enable(rx_en),
        .nine_bit(nine),
        .sample_tick(sample_tick),
        .rx_line(line_in),
        .char_done(char_done),
        .char_data(char_data),
        .char_stop_ok(char_stop_ok)
    );

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            csb_q <= urp_pkg::CSB_RESET;
            port_q <= 2'b00;
            rdr_q <= 9'h000;
            rxc_q <= 1'b0;
            fe_q <= 1'b0;
            or_q <= 1'b0;
            or_pend_q <= 1'b0;
            tx_data <= 8'h00;
            tx_ninth <= 1'b0;
            tx_load <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_load <= 1'b0;
            if (wr && hit_data)
            begin
                tx_data <= pwdata[7:0];
                tx_ninth <= csb_q[urp_pkg::CSB_TXB8];
                tx_load <= 1'b1;
            end
            if (wr && hit_csb)
                csb_q <= pwdata[7:0];
            if (wr && hit_port)
                port_q <= pwdata[1:0];
            if (char_done && !overrun)
            begin
                rdr_q <= nine ? char_data : {1'b0, char_data[7:0]};
                fe_q <= !char_stop_ok;
                rxc_q <= 1'b1;
            end
            else if (data_read)
                rxc_q <= 1'b0;
            if (overrun)
                or_pend_q <= 1'b1;
            if (data_read)
            begin
                or_q <= or_pend_q || overrun;
                if (!overrun)
                    or_pend_q <= 1'b0;
            end
        end
    end

    always_comb
    begin
        prdata = rd_mux;
    end

    wire unused_bits = |pwdata[31:8];

    a_frame_err: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && char_done && !overrun |=> fe_q == !$past(char_stop_ok))
        else $error("framing flag wrong");
    a_rx_complete: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && char_done && !overrun |=> rxc_q && rdr_q[7:0] == $past(char_data[7:0]))
        else $error("character not loaded");
    a_overrun_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && overrun |=> rdr_q == $past(rdr_q))
        else $error("overrun overwrote data");
    a_or_on_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(clk_en && data_read) |=> or_q == $past(or_q))
        else $error("overrun flag moved without read");
    a_pin_input: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rx_en |-> !rx_pin_oe && rx_pin_pullup == port_q[urp_pkg::PRT_OUT])
        else $error("pin not forced to input");
    a_ninth_rx: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && char_done && !overrun && nine
        |=> csb_val[urp_pkg::CSB_RXB8] == $past(char_data[8]))
        else $error("ninth bit not loaded");
    a_tx_ninth: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && wr && hit_data |=> tx_load && tx_ninth == $past(csb_q[urp_pkg::CSB_TXB8]))
        else $error("ninth transmit bit wrong");
endmodule

// *** verif/urp_serial_src.sv ***
`timescale 1ns/1ns
module urp_serial_src (
    // Clock
    input wire logic sys_clk,
    // Serial side
    output logic sample_tick,
    output logic line
);
    logic [1:0] div_q = 2'h0;

    initial line = 1'b1;

    always @(posedge sys_clk)
    begin
        div_q <= div_q + 2'h1;
    end

    // One tick every four clocks, sixteen ticks per bit
    assign sample_tick = (div_q == 2'h3);

    task automatic tick_wait(input int n);
        repeat (n)
        begin
            @(posedge sys_clk iff sample_tick);
        end
    endtask

    // Frame: start, data lsb first, optional ninth bit, stop; gl flips data ticks
    task automatic send(input logic [8:0] d, input logic nine, input logic stop,
        input logic [15:0] gl);
        logic [10:0] bits;
        int n;
        bits = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        n = nine ? 11 : 10;
        for (int b = 0; b < n; b++)
        begin
            for (int t = 0; t < 16; t++)
            begin
                line <= (b > 0 && b < n - 1 && gl[t]) ? ~bits[b] : bits[b];
                tick_wait(1);
            end
        end
        line <= 1'b1;
        tick_wait(16);
    endtask

    // Short low pulse that must not start a character
    task automatic noise();
        line <= 1'b0;
        tick_wait(3);
        line <= 1'b1;
        tick_wait(180);
    endtask
endmodule

// *** verif/uart_receive_path_tb.sv ***
`timescale 1ns/1ns
module uart_receive_path_tb;
    typedef struct packed {
        logic [8:0] d;
        logic nine;
        logic stop;
        logic [15:0] gl;
    } urp_row_t;

    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, sample_tick, src_line, rx_pin_in;
    logic rx_pin_out, rx_pin_oe, rx_pin_pullup, tx_ninth, tx_load;
    logic [7:0] tx_data;
    int fails = 0;
    int checks = 0;
    urp_row_t rows [6];

    always #5 sys_clk = ~sys_clk;

    assign rx_pin_in = rx_pin_oe ? rx_pin_out : src_line;

    urp_serial_src i_urp_serial_src (.sys_clk(sys_clk), .sample_tick(sample_tick),
        .line(src_line));

    urp_uart_rx i_urp_uart_rx (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
        .rx_pin_in(rx_pin_in), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe),
        .rx_pin_pullup(rx_pin_pullup), .tx_data(tx_data), .tx_ninth(tx_ninth),
        .tx_load(tx_load));

    task automatic end_sim();
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1)
        begin
            fails++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_rx();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, urp_pkg::OFF_CSA, 32'h0);
            n++;
        end
        while (rd[urp_pkg::CSA_RXC] !== 1'b1 && n < 40);
        if (rd[urp_pkg::CSA_RXC] !== 1'b1)
        begin
            fails++;
            end_sim();
        end
    endtask

    initial
    begin
        rows[0] = '{9'h055, 1'b0, 1'b1, 16'h0000};
        rows[1] = '{9'h0c3, 1'b0, 1'b1, 16'h0107};
        rows[2] = '{9'h000, 1'b0, 1'b1, 16'h0100};
        rows[3] = '{9'h0ff, 1'b0, 1'b0, 16'h0000};
        rows[4] = '{9'h1a5, 1'b1, 1'b1, 16'h0000};
        rows[5] = '{9'h05a, 1'b1, 1'b1, 16'h0000};
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, urp_pkg::OFF_CSA, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, urp_pkg::OFF_CSB, 32'h0);
        check(rd, {24'h0, urp_pkg::CSB_RESET});
        apb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, urp_pkg::OFF_PORT, 32'h3);
        #1 check({rx_pin_oe, rx_pin_out}, 2'b11);
        foreach (rows[i])
        begin
            apb(1'b1, urp_pkg::OFF_CSB, 32'h11 | (rows[i].nine << urp_pkg::CSB_CHR9));
            #1 check({rx_pin_oe, rx_pin_pullup}, 2'b01);
            i_urp_serial_src.send(rows[i].d, rows[i].nine, rows[i].stop, rows[i].gl);
            wait_rx();
            check(rd[urp_pkg::CSA_FE], !rows[i].stop);
            apb(1'b0, urp_pkg::OFF_CSB, 32'h0);
            check(rd[urp_pkg::CSB_RXB8], rows[i].nine & rows[i].d[8]);
            apb(1'b0, urp_pkg::OFF_DATA, 32'h0);
            check(rd[7:0], rows[i].d[7:0]);
        end
        apb(1'b1, urp_pkg::OFF_DATA, 32'h3c);
        #1 check({tx_load, tx_ninth, tx_data}, {2'b11, 8'h3c});
        apb(1'b0, urp_pkg::OFF_DATA, 32'h0);
        check(rd[7:0], 8'h5a);
        apb(1'b1, urp_pkg::OFF_CSB, 32'h10);
        i_urp_serial_src.send(9'h011, 1'b0, 1'b1, 16'h0);
        i_urp_serial_src.send(9'h022, 1'b0, 1'b1, 16'h0);
        wait_rx();
        check(rd[urp_pkg::CSA_OR], 1'b0);
        apb(1'b0, urp_pkg::OFF_DATA, 32'h0);
        check(rd[7:0], 8'h11);
        apb(1'b0, urp_pkg::OFF_CSA, 32'h0);
        check({rd[urp_pkg::CSA_RXC], rd[urp_pkg::CSA_OR]}, 2'b01);
        i_urp_serial_src.noise();
        apb(1'b0, urp_pkg::OFF_CSA, 32'h0);
        check(rd[urp_pkg::CSA_RXC], 1'b0);
        apb(1'b1, urp_pkg::OFF_PORT, 32'h1);
        #1 check({rx_pin_oe, rx_pin_pullup}, 2'b00);
        apb(1'b1, urp_pkg::OFF_CSB, 32'h0);
        #1 check({rx_pin_oe, rx_pin_out}, 2'b10);
        // Clock enable low: the write must not land
        clk_en <= 1'b0;
        apb(1'b1, urp_pkg::OFF_PORT, 32'h2);
        clk_en <= 1'b1;
        apb(1'b0, urp_pkg::OFF_PORT, 32'h0);
        check(rd, 32'h1);
        // Mid-run reset clears the held overrun flag and the port
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, urp_pkg::OFF_CSA, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, urp_pkg::OFF_PORT, 32'h0);
        check(rd, 32'h0);
        end_sim();
    end
endmodule
